// >>> awg_params.svh
// Functional notes
// R1 - Each aux trigger picks one of eight lines: four trigger inputs, four outputs.
// R2 - Trigger slope: 0 level, 1 rising, 2 falling, last code either edge.
// R3 - Either-edge code of trigger and strobe slope settings is value 3.
// R4 - Read-only per-trigger state bit shows qualified trigger detected.
// R5 - Each digital input bit delayed 0 to 3 cycles, chosen by index then value.
// R6 - Software-selected input bit serves as strobe for capture alignment.
// R7 - Strobe slope: 0 off, 1 rising, 2 falling, 3 either edge.
// R8 - Software-selected input bit marks a valid input word.
// R9 - Valid polarity: 0 ignore, 1 low, 2 high, 3 either level.
// R10 - Ready flag rises once a compiled program is loaded.
// R11 - Single-shot setting runs the program once per activation.
// R12 - Status bit 0 running, bit 2 waiting trigger, bit 1 reserved.
// R13 - Status bit 3 error detected, bit 4 waiting for channel sync.
// R14 - Current instruction index is readable.
// R15 - Instruction memory holds 1024 instructions; size reported as fraction. Code reports a word count on image_words instead.
// R16 - Program image enters by write-only data; length, checksum, progress reported.
// R17 - Output mode 0 passes generator output straight through.
// R18 - Output mode 1 multiplies generator output by oscillator signal.
// R19 - Advanced mode lets generator supply envelopes for four demodulators.
// R20 - Each output scaled by amplitude fraction of full scale.
// R21 - Read-only flags show routing to wave output or mixer input.
`ifndef AWG_PARAMS_SVH
`define AWG_PARAMS_SVH
`define AWG_NUM_TRIG 2
`define AWG_DIO_W 32
`define AWG_IMEM_DEPTH 1024
`define AWG_IMEM_AW 10
`define AWG_DELAY_MAX 3
`define AWG_SLOPE_LEVEL 2'h0
`define AWG_SLOPE_RISE 2'h1
`define AWG_SLOPE_FALL 2'h2
`define AWG_SLOPE_BOTH 2'h3
`define AWG_POL_NONE 2'h0
`define AWG_POL_LOW 2'h1
`define AWG_POL_HIGH 2'h2
`define AWG_POL_BOTH 2'h3
`define AWG_ST_RUN 0
`define AWG_ST_WTRIG 2
`define AWG_ST_ERR 3
`define AWG_ST_WSYNC 4
`define AWG_MODE_PLAIN 2'h0
`define AWG_MODE_MOD 2'h1
`define AWG_MODE_ADV 2'h2
`define AWG_SAMPLE_W 16
`define AWG_INSTR_W 32
`endif

// >>> awg_pkg.sv
package awg_pkg;
	typedef struct packed {
		logic [2:0] channel;
		logic [1:0] slope;
	} awg_trig_cfg_t;
	typedef struct packed {
		logic [4:0] strobe_index;
		logic [1:0] strobe_slope;
		logic [4:0] valid_index;
		logic [1:0] valid_pol;
	} awg_dio_cfg_t;
	typedef struct packed {
		logic wait_sync;
		logic error;
		logic wait_trig;
		logic reserved;
		logic running;
	} awg_status_t;
	typedef enum logic [2:0] {
		AWG_IDLE = 3'b000,
		AWG_WAIT_TRIG = 3'b001,
		AWG_WAIT_SYNC = 3'b010,
		AWG_RUN = 3'b011,
		AWG_ERR = 3'b100
	} awg_state_t;
endpackage

// >>> awg_imem.sv
`timescale 1ns/100ps
`default_nettype none
module awg_imem #(
	parameter int DEPTH = 1024,
	parameter int AW = 10,
	parameter int DW = 32
) (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	// Read port
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem [DEPTH];
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// >>> awg_dio_delay.sv
`timescale 1ns/100ps
`default_nettype none
`include "awg_params.svh"
module awg_dio_delay #(
	parameter int W = 32,
	parameter int IW = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Delay programming
	input wire logic [IW-1:0] delay_index,
	input wire logic [1:0] delay_value,
	input wire logic delay_write,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [1:0] sel_q [W];
	logic [2:0] tap_q [W];
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			wire logic hit;
			assign hit = delay_write && (delay_index == IW'(i));
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					sel_q[i] <= 2'h0;
					tap_q[i] <= 3'h0;
				end else begin
					if (hit) begin
						sel_q[i] <= delay_value; // [R5]
					end
					tap_q[i] <= {tap_q[i][1:0], din[i]};
				end
			end
			// Tap 0 is the synchronised bit itself
			assign dout[i] = (sel_q[i] == 2'h0) ? din[i] :
				tap_q[i][sel_q[i] - 2'h1]; // [R5]
		end
	endgenerate
endmodule
`default_nettype wire

// >>> awg_seq_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "awg_params.svh"
module awg_seq_ctrl #(
	parameter int NT = `AWG_NUM_TRIG,
	parameter int DW = `AWG_DIO_W,
	parameter int DEPTH = `AWG_IMEM_DEPTH,
	parameter int AW = `AWG_IMEM_AW,
	parameter int SW = `AWG_SAMPLE_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Trigger connectors, asynchronous
	input wire logic [3:0] trigger_connector_in_first,
	input wire logic [3:0] trigger_connector_out_first,
	// Aux trigger settings and state
	input wire awg_pkg::awg_trig_cfg_t trig_cfg [NT],
	output logic [NT-1:0] trig_state,
	// Parallel digital input, asynchronous
	input wire logic [DW-1:0] dio_in,
	input wire awg_pkg::awg_dio_cfg_t dio_cfg,
	input wire logic [4:0] delay_index,
	input wire logic [1:0] delay_value,
	input wire logic delay_write,
	output logic [DW-1:0] dio_word,
	output logic dio_word_valid,
	// Program image upload
	input wire logic image_start,
	input wire logic [31:0] image_total,
	input wire logic image_wr,
	input wire logic [`AWG_INSTR_W-1:0] image_data,
	output logic [31:0] image_length,
	output logic [31:0] image_checksum,
	output logic [6:0] image_progress,
	output logic [AW:0] image_words,
	output logic ready,
	// Sequencer control
	input wire logic enable,
	input wire logic single,
	input wire logic sync_done,
	input wire logic trig_needed,
	output logic enable_clear,
	output awg_pkg::awg_status_t status,
	output logic [AW-1:0] instruction_position,
	output logic [`AWG_INSTR_W-1:0] instruction,
	// Output path
	input wire logic [1:0] out_mode,
	input wire logic [SW-1:0] amplitude,
	input wire logic signed [SW-1:0] osc_sample,
	output logic signed [SW-1:0] wave_out,
	output logic [3:0] envelope_sel,
	output logic route_wave,
	output logic route_mixer
);
	// Two-stage synchronisers for all pin inputs
	logic [7:0] trg_s1_q, trg_s2_q, trg_prev_q;
	logic [DW-1:0] dio_s1_q, dio_s2_q;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			trg_s1_q <= 8'h00;
			trg_s2_q <= 8'h00;
			trg_prev_q <= 8'h00;
			dio_s1_q <= '0;
			dio_s2_q <= '0;
		end else begin
			trg_s1_q <= {trigger_connector_out_first, trigger_connector_in_first};
			trg_s2_q <= trg_s1_q;
			trg_prev_q <= trg_s2_q;
			dio_s1_q <= dio_in;
			dio_s2_q <= dio_s1_q;
		end
	end

	// Aux triggers
	logic [NT-1:0] trig_hit;
	logic [NT-1:0] trig_state_q;
	genvar t;
	generate
		for (t = 0; t < NT; t++) begin : g_trig
			wire logic cur, prv;
			assign cur = trg_s2_q[trig_cfg[t].channel]; // [R1]
			assign prv = trg_prev_q[trig_cfg[t].channel];
			assign trig_hit[t] =
				(trig_cfg[t].slope == `AWG_SLOPE_LEVEL) ? cur :
				(trig_cfg[t].slope == `AWG_SLOPE_RISE) ? (cur && !prv) :
				(trig_cfg[t].slope == `AWG_SLOPE_FALL) ? (!cur && prv) :
				(cur != prv); // [R2] [R3]
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					trig_state_q[t] <= 1'b0;
				end else begin
					trig_state_q[t] <= trig_hit[t]; // [R4]
				end
			end
		end
	endgenerate
	assign trig_state = trig_state_q;

	// Per-bit delay then strobe and valid qualification
	logic [DW-1:0] dio_dly;
	awg_dio_delay #(.W(DW), .IW(5)) u_delay (
		.clk(clk),
		.rst_b(rst_b),
		.delay_index(delay_index),
		.delay_value(delay_value),
		.delay_write(delay_write),
		.din(dio_s2_q),
		.dout(dio_dly)
	);
	logic strobe_prev_q;
	logic [DW-1:0] dio_word_q;
	logic dio_valid_q;
	wire logic strobe_now = dio_dly[dio_cfg.strobe_index]; // [R6]
	wire logic valid_bit = dio_dly[dio_cfg.valid_index]; // [R8]
	wire logic strobe_ok =
		(dio_cfg.strobe_slope == `AWG_SLOPE_LEVEL) ? 1'b1 :
		(dio_cfg.strobe_slope == `AWG_SLOPE_RISE) ?
			(strobe_now && !strobe_prev_q) :
		(dio_cfg.strobe_slope == `AWG_SLOPE_FALL) ?
			(!strobe_now && strobe_prev_q) :
		(strobe_now != strobe_prev_q); // [R7] [R3]
	wire logic valid_ok =
		(dio_cfg.valid_pol == `AWG_POL_LOW) ? !valid_bit :
		(dio_cfg.valid_pol == `AWG_POL_HIGH) ? valid_bit :
		1'b1; // [R9]
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			strobe_prev_q <= 1'b0;
			dio_word_q <= '0;
			dio_valid_q <= 1'b0;
		end else begin
			strobe_prev_q <= strobe_now;
			dio_valid_q <= strobe_ok && valid_ok;
			if (strobe_ok && valid_ok) begin
				dio_word_q <= dio_dly;
			end
		end
	end
	assign dio_word = dio_word_q;
	assign dio_word_valid = dio_valid_q;

	// Program image upload
	logic [31:0] len_q, sum_q, total_q;
	logic ready_q;
	logic [AW-1:0] pc_q;
	wire logic mem_full = (len_q >= 32'(DEPTH));
	wire logic load_wr = image_wr && !mem_full; // [R15]
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			len_q <= 32'h0;
			sum_q <= 32'h0;
			total_q <= 32'h0;
			ready_q <= 1'b0;
		end else if (image_start) begin
			len_q <= 32'h0;
			sum_q <= 32'h0;
			total_q <= image_total;
			ready_q <= 1'b0;
		end else begin
			if (load_wr) begin
				len_q <= len_q + 32'h1; // [R16]
				sum_q <= sum_q + image_data;
			end
			// Ready once the announced image is complete
			if (total_q != 32'h0 && len_q == total_q) begin
				ready_q <= 1'b1; // [R10]
			end
		end
	end
	assign image_length = len_q;
	assign image_checksum = sum_q;
	assign image_words = (AW+1)'(len_q); // [R15]
	assign ready = ready_q;
	// Progress is a percentage of the announced total, divided each cycle
	wire logic [38:0] pct_num = 39'(len_q) * 39'd100;
	assign image_progress = (total_q == 32'h0) ? 7'h0 :
		7'(pct_num / 39'(total_q)); // [R16]

	awg_imem #(.DEPTH(DEPTH), .AW(AW), .DW(`AWG_INSTR_W)) u_imem (
		.clk(clk),
		.wr_en(load_wr),
		.wr_addr(len_q[AW-1:0]),
		.wr_data(image_data),
		.rd_addr(pc_q),
		.rd_data(instruction)
	);

	// Sequencer
	awg_pkg::awg_state_t st_q, st_d;
	logic en_prev_q;
	wire logic start = enable && !en_prev_q && ready_q;
	wire logic last = (32'(pc_q) + 32'h1 >= len_q);
	wire logic any_trig = |trig_state_q;
	always_comb begin
		st_d = st_q;
		case (st_q)
			awg_pkg::AWG_IDLE: begin
				if (start) begin
					st_d = awg_pkg::AWG_WAIT_SYNC;
				end
			end
			awg_pkg::AWG_WAIT_SYNC: begin
				if (!enable) begin
					st_d = awg_pkg::AWG_IDLE;
				end else if (sync_done) begin
					st_d = trig_needed ? awg_pkg::AWG_WAIT_TRIG :
						awg_pkg::AWG_RUN;
				end
			end
			awg_pkg::AWG_WAIT_TRIG: begin
				if (!enable) begin
					st_d = awg_pkg::AWG_IDLE;
				end else if (any_trig) begin
					st_d = awg_pkg::AWG_RUN;
				end
			end
			awg_pkg::AWG_RUN: begin
				if (!enable) begin
					st_d = awg_pkg::AWG_IDLE;
				end else if (!ready_q) begin
					st_d = awg_pkg::AWG_ERR;
				end else if (last && single) begin
					st_d = awg_pkg::AWG_IDLE; // [R11]
				end
			end
			awg_pkg::AWG_ERR: begin
				if (!enable) begin
					st_d = awg_pkg::AWG_IDLE;
				end
			end
			default: st_d = awg_pkg::AWG_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_q <= awg_pkg::AWG_IDLE;
			en_prev_q <= 1'b0;
			pc_q <= '0;
		end else begin
			st_q <= st_d;
			en_prev_q <= enable;
			if (st_q != awg_pkg::AWG_RUN) begin
				pc_q <= '0;
			end else if (last) begin
				pc_q <= '0;
			end else begin
				pc_q <= pc_q + 1'b1; // [R14]
			end
		end
	end
	assign enable_clear = (st_q == awg_pkg::AWG_RUN) && last && single; // [R11]
	assign instruction_position = pc_q; // [R14]
	assign status.running = (st_q == awg_pkg::AWG_RUN); // [R12]
	assign status.reserved = 1'b0; // [R12]
	assign status.wait_trig = (st_q == awg_pkg::AWG_WAIT_TRIG); // [R12]
	assign status.error = (st_q == awg_pkg::AWG_ERR); // [R13]
	assign status.wait_sync = (st_q == awg_pkg::AWG_WAIT_SYNC); // [R13]

	// Output path: sample is the low instruction bits
	wire logic signed [SW-1:0] gen = instruction[SW-1:0];
	wire logic signed [2*SW:0] scaled = gen * $signed({1'b0, amplitude});
	wire logic signed [SW-1:0] gen_amp = scaled[2*SW-1:SW]; // [R20]
	wire logic signed [2*SW-1:0] modp = gen_amp * osc_sample;
	logic signed [SW-1:0] wave_q;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wave_q <= '0;
		end else if (out_mode == `AWG_MODE_MOD) begin
			wave_q <= modp[2*SW-2:SW-1]; // [R18]
		end else begin
			wave_q <= gen_amp; // [R17] [R19]
		end
	end
	assign wave_out = wave_q;
	assign envelope_sel = (out_mode == `AWG_MODE_ADV) ? 4'hf : 4'h0; // [R19]
	assign route_wave = (out_mode != `AWG_MODE_ADV); // [R21]
	assign route_mixer = (out_mode == `AWG_MODE_ADV); // [R21]
endmodule
`default_nettype wire

// >>> awg_seq_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
module awg_seq_ctrl_props #(
	parameter int NT = 2,
	parameter int AW = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Triggers
	input wire logic [3:0] trigger_connector_in_first,
	input wire logic [3:0] trigger_connector_out_first,
	input wire awg_pkg::awg_trig_cfg_t trig_cfg [NT],
	input wire logic [NT-1:0] trig_state,
	// Upload
	input wire logic image_start,
	input wire logic image_wr,
	input wire logic [31:0] image_data,
	input wire logic [31:0] image_length,
	input wire logic [31:0] image_checksum,
	input wire logic ready,
	// Sequencer
	input wire logic enable,
	input wire awg_pkg::awg_status_t status,
	input wire logic [AW-1:0] instruction_position
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire logic [7:0] lines;
	wire logic line0;
	wire logic lvl0;
	wire logic edge0;
	wire logic wr_ok;
	assign lines = {trigger_connector_out_first, trigger_connector_in_first};
	assign line0 = lines[trig_cfg[0].channel];
	assign lvl0 = trig_cfg[0].slope == 2'h0;
	assign edge0 = trig_cfg[0].slope == 2'h1 || trig_cfg[0].slope == 2'h2;
	assign wr_ok = image_wr && !image_start && image_length < 32'h400;
	// Sync stages plus register give three edges of latency
	sequence s_hi; (lvl0 && line0)[*4]; endsequence
	sequence s_lo; (lvl0 && !line0)[*4]; endsequence
	property p_lvl_hi; s_hi |-> trig_state[0]; endproperty
	a_lvl_hi: assert property (p_lvl_hi) else $error("level trig low");
	property p_lvl_lo; s_lo |-> !trig_state[0]; endproperty
	a_lvl_lo: assert property (p_lvl_lo) else $error("level trig high");
	property p_pulse; edge0 && trig_state[0] |=> !trig_state[0]; endproperty
	a_pulse: assert property (p_pulse) else $error("edge trig long");
	property p_rsv; !status.reserved; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	property p_rdy; ready |-> image_length != 32'h0; endproperty
	a_rdy: assert property (p_rdy) else $error("ready with no image");
	property p_len;
		wr_ok |=> image_length == $past(image_length) + 32'h1;
	endproperty
	a_len: assert property (p_len) else $error("length not counted");
	property p_sum;
		wr_ok |=> image_checksum == $past(image_checksum) + $past(image_data);
	endproperty
	a_sum: assert property (p_sum) else $error("checksum wrong");
	property p_sync;
		$rose(enable) && ready && status == 5'h00 |=> status.wait_sync;
	endproperty
	a_sync: assert property (p_sync) else $error("no sync wait");
	property p_pc;
		status.running && enable && ready &&
			32'(instruction_position) + 32'h1 < image_length |=>
			instruction_position == $past(instruction_position) + 1'b1;
	endproperty
	a_pc: assert property (p_pc) else $error("position stuck");
endmodule
`default_nettype wire

// >>> awg_ext_equip.sv
`timescale 1ns/100ps
`default_nettype none
module awg_ext_equip (
	// Lines toward the block
	output logic [3:0] trig_in,
	output logic [3:0] trig_out,
	output logic [31:0] dio
);
	initial begin
		trig_in = 4'h0;
		trig_out = 4'h0;
		dio = 32'h0;
	end
	task line(input int i, input logic v);
		if (i < 4) trig_in[i] = v;
		else trig_out[i-4] = v;
	endtask
	// Caller picks the valid level for the polarity under
	task word(input logic [31:0] w);
		dio = w;
	endtask
endmodule
`default_nettype wire

// >>> awg_trigger_dio_sequencer_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module awg_trigger_dio_sequencer_control_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] tin, tout;
	logic [31:0] dio_in;
	awg_pkg::awg_trig_cfg_t trig_cfg [2];
	awg_pkg::awg_dio_cfg_t dio_cfg;
	logic delay_write, image_start, image_wr, enable, sync_done, trig_needed;
	logic [4:0] delay_index;
	logic [1:0] delay_value;
	logic single;
	logic [31:0] image_total, image_data, image_length, image_checksum;
	logic [1:0] out_mode;
	logic [1:0] trig_state;
	logic [31:0] dio_word, instruction;
	logic dio_word_valid, ready, enable_clear, route_wave, route_mixer;
	logic [6:0] image_progress;
	logic [10:0] image_words;
	awg_pkg::awg_status_t status;
	logic [9:0] instruction_position;
	logic [15:0] wave_out;
	logic [3:0] envelope_sel;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	always #12.5 clk = ~clk;
	awg_ext_equip ext_i (.trig_in(tin), .trig_out(tout), .dio(dio_in));
	awg_seq_ctrl awg_seq_ctrl_i (.clk, .rst_b,
		.trigger_connector_in_first(tin), .trigger_connector_out_first(tout),
		.trig_cfg, .trig_state, .dio_in, .dio_cfg, .delay_index,
		.delay_value, .delay_write, .dio_word, .dio_word_valid,
		.image_start, .image_total, .image_wr, .image_data, .image_length,
		.image_checksum, .image_progress, .image_words, .ready, .enable,
		.single, .sync_done, .trig_needed, .enable_clear, .status,
		.instruction_position, .instruction, .out_mode,
		.amplitude(16'h8000), .osc_sample(16'h1234), .wave_out,
		.envelope_sel, .route_wave, .route_mixer);
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task cyc_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task t_trig;
		logic [31:0] n;
		for (int s = 0; s < 4; s++) begin
			trig_cfg[1] = awg_pkg::awg_trig_cfg_t'({3'h2, 2'(s)});
			trig_cfg[0] = trig_cfg[1];
			ext_i.line(2, 1'b0);
			cyc_n(8);
			for (int e = 1; e >= 0; e--) begin
				ext_i.line(2, e[0]);
				n = 0;
				repeat (8) begin
					@(negedge clk);
					n += trig_state[1];
				end
				if (s == 0) chk("level", trig_state[1], e);
				else chk("edges", n, {e[0] ? 4'b1010 : 4'b1100} >> s & 1);
			end
		end
		$display("trigger slopes done");
	endtask
	task t_dio;
		logic [31:0] n;
		dio_cfg = '{5'd31, 2'h1, 5'd30, 2'h0};
		delay_write = 1'b1;
		cyc_n(1);
		delay_write = 1'b0;
		for (int p = 0; p < 4; p++) begin
			dio_cfg.valid_pol = 2'(p);
			ext_i.word(32'h4000_1234);
			cyc_n(6);
			ext_i.word(32'hc000_1234);
			n = 0;
			repeat (8) begin
				@(negedge clk);
				if (dio_word_valid === 1'b1) begin
					n++;
					chk("word", dio_word, 32'hc000_1234);
				end
			end
			chk("valid", n, p == 1 ? 0 : 1);
		end
		// Strobe bit held back three taps shifts capture by three cycles
		ext_i.word(32'h4000_1234);
		delay_index = 5'd31;
		delay_value = 2'h3;
		delay_write = 1'b1;
		cyc_n(1);
		delay_write = 1'b0;
		cyc_n(6);
		ext_i.word(32'hc000_1234);
		n = 0;
		repeat (10) begin
			@(negedge clk);
			n++;
			if (dio_word_valid === 1'b1) break;
		end
		chk("delay", n, 32'h6);
		$display("digital input done");
	endtask
	task t_upload;
		image_total = 32'h3;
		image_start = 1'b1;
		cyc_n(1);
		image_start = 1'b0;
		image_wr = 1'b1;
		for (int w = 1; w < 4; w++) begin
			image_data = 32'h1000_0001 * w;
			cyc_n(1);
		end
		image_wr = 1'b0;
		cyc_n(2);
		chk("length", image_length, 32'h3);
		chk("sum", image_checksum, 32'h6000_0006);
		chk("progress", image_progress, 7'h64);
		chk("ready", ready, 1'b1);
		$display("upload done");
	endtask
	task t_seq;
		logic [31:0] n;
		trig_cfg[0] = awg_pkg::awg_trig_cfg_t'({3'h4, 2'h1});
		ext_i.line(4, 1'b0);
		trig_needed = 1'b1;
		enable = 1'b1;
		cyc_n(2);
		chk("wsync", status, 5'h10);
		sync_done = 1'b1;
		cyc_n(2);
		chk("wtrig", status, 5'h04);
		ext_i.line(4, 1'b1);
		n = 0;
		repeat (8) begin
			@(negedge clk);
			if (status.running === 1'b1) n = 1;
		end
		chk("run", n, 1);
		enable = 1'b0;
		cyc_n(2);
		chk("idle", status, 5'h00);
		// Single shot over the three loaded words stops by itself
		single = 1'b1;
		trig_needed = 1'b0;
		enable = 1'b1;
		n = 0;
		repeat (10) begin
			@(negedge clk);
			n += enable_clear;
		end
		chk("single pulses", n, 32'h1);
		chk("single idle", status, 5'h00);
		enable = 1'b0;
		single = 1'b0;
		cyc_n(2);
		out_mode = 2'h0;
		cyc_n(1);
		chk("plain", route_wave, 1'b1);
		out_mode = 2'h2;
		cyc_n(1);
		chk("envelope", envelope_sel, 4'hf);
		$display("sequencer done");
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			print_verdict;
		end
	end
	initial begin
		trig_cfg[0] = '0;
		trig_cfg[1] = '0;
		dio_cfg = '0;
		{delay_write, image_start, image_wr, enable, sync_done} = 5'h0;
		{trig_needed, out_mode, image_total, image_data} = '0;
		delay_index = 5'h00;
		delay_value = 2'h0;
		single = 1'b0;
		cyc_n(8);
		rst_b = 1'b1;
		cyc_n(1);
		t_trig;
		t_dio;
		t_upload;
		t_seq;
		print_verdict;
	end
endmodule
bind awg_seq_ctrl awg_seq_ctrl_props #(.NT(NT), .AW(AW)) props_i (.clk,
	.rst_b, .trigger_connector_in_first, .trigger_connector_out_first,
	.trig_cfg, .trig_state, .image_start, .image_wr, .image_data,
	.image_length, .image_checksum, .ready, .enable, .status,
	.instruction_position);
`default_nettype wire
